/* File: rtl/fspc_top.sv */
// flash self-program control: apb register, page buffer, sequencing
`timescale 1ns/1ps
module fspc_top #(
  parameter bit          RWW_SUPPORT = 1'b1,                 // variant has read-while-write
  parameter int unsigned PROG_CYC    = fspc_pkg::PROG_CYCLES, // programming time in cycles
  parameter logic [31:0] SIG_ROW     = 32'h5A3C_0F96          // arbitrary signature bytes
) (
  input  wire logic        pclk,           // cpu clock 50 MHz
  input  wire logic        presetn,        // async reset, low
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb write
  input  wire logic [11:0] paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic [31:0]      prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb error, unmapped
  input  wire logic        spm_exec,       // store instruction pulse
  input  wire logic        lpm_exec,       // load instruction pulse
  input  wire logic [15:0] z_ptr,          // address pointer
  input  wire logic [15:0] data_pair,      // data register pair
  input  wire logic [14:0] cpu_pc,         // word address of the store
  input  wire logic        global_int_en,  // status register i-bit
  input  wire logic        ee_write_busy,  // eeprom write running
  input  wire logic [1:0]  section_size_fuses, // boot size fuses
  input  wire logic [7:0]  fuse_low_prog,  // 1 = programmed
  input  wire logic [7:0]  fuse_high_prog, // 1 = programmed
  input  wire logic [7:0]  fuse_ext_prog,  // 1 = programmed
  input  wire logic [7:0]  lock_prog,      // 1 = programmed
  input  wire logic [5:0]  buf_rd_idx,     // flash macro buffer index
  output logic [15:0]      buf_rd_data,    // buffer word, registered
  output logic             lpm_valid,      // special load answer pulse
  output logic [7:0]       lpm_data,       // special load byte
  output logic             ready_irq,      // ready interrupt request
  output logic             cpu_halt,       // halt processor
  output logic             flash_erase,    // erase start pulse
  output logic             flash_write,    // write start pulse
  output logic [8:0]       flash_page      // latched page
);
  import fspc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                    ie_r, sbusy_r, sig_r, rre_r, blb_r, pgw_r, pge_r, store_enable_r;
  fspc_op_type             op_r;
  logic                    op_no_read_while_write_section_r;
  logic [15:0]             buf_mem [PAGE_WORDS];
  logic [PAGE_WORDS-1:0]   buf_vld_r;
  logic [PAGE_WORDS-1:0]   buf_vld_nxt;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic        setup_c, access_c, hit_c, wr_csr_c;
  logic [4:0]  pat_c;
  logic        pat_ok_c, cmd_ok_c;
  logic [7:0]  csr_rd_c;
  logic        sbusy_rd_c;

  assign setup_c    = psel && !penable;
  assign access_c   = psel && penable && pready;
  assign hit_c      = (paddr == CSR_ADDR);
  assign wr_csr_c   = access_c && pwrite && hit_c;
  assign pat_c      = pwdata[4:0];
  // only five patterns are accepted, others ignored
  assign pat_ok_c   = (pat_c == PAT_RRE) || (pat_c == PAT_BLB) || (pat_c == PAT_PGW) ||
                      (pat_c == PAT_PGE) || (pat_c == PAT_SPM); // R14
  assign cmd_ok_c   = wr_csr_c && pat_ok_c && (op_r == OP_IDLE);
  assign sbusy_rd_c = RWW_SUPPORT ? sbusy_r : 1'b0; // R3
  assign csr_rd_c   = {ie_r, sbusy_rd_c, sig_r, rre_r, blb_r, pgw_r, pge_r, store_enable_r};

  // one wait-free access phase, read data captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_c;
      pslverr <= setup_c && !hit_c;
      if (setup_c) begin
        prdata <= hit_c ? {24'h00_0000, csr_rd_c} : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // arming window and programming timer
  // ----------------------------------------------------------------
  logic spm_win, lpm_win, expire, prog_done;
  logic spm_fire_c, lpm_fire_c, start_c;

  fspc_arm_window u_arm (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (cmd_ok_c),
    .stop    (spm_fire_c),
    .spm_win (spm_win),
    .lpm_win (lpm_win),
    .expire  (expire)
  );

  fspc_prog_timer #(.PROG_CYC(PROG_CYC)) u_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (start_c),
    .done    (prog_done)
  );

  // ----------------------------------------------------------------
  // section decode
  // ----------------------------------------------------------------
  logic [14:0] boot_words_c, boot_start_c, app_end_c;
  logic        in_boot_c, z_no_read_while_write_section_c;

  assign boot_words_c = (section_size_fuses == 2'h0) ? BOOT_W_00 :
                        (section_size_fuses == 2'h1) ? BOOT_W_01 :
                        (section_size_fuses == 2'h2) ? BOOT_W_10 : BOOT_W_11;
  assign app_end_c    = FLASH_WORDS_M1 - boot_words_c + 15'h1;
  // boot section is clamped so it never leaves the no_read_while_write_section section
  assign boot_start_c = (app_end_c < NO_READ_WHILE_WRITE_SECTION_START) ? NO_READ_WHILE_WRITE_SECTION_START : app_end_c; // R21
  assign in_boot_c    = (cpu_pc >= boot_start_c); // R15
  // any target page is allowed, including boot pages
  assign z_no_read_while_write_section_c     = (z_ptr[15:1] >= NO_READ_WHILE_WRITE_SECTION_START); // R16

  // ----------------------------------------------------------------
  // store and load decode
  // ----------------------------------------------------------------
  logic        fill_c, ctrl_clr_c;
  logic        halt_sel_c;
  logic [7:0]  lpm_byte_c, fuse_sel_c;

  // stores from the application section are ignored
  assign spm_fire_c = spm_exec && spm_win && store_enable_r && in_boot_c && (op_r == OP_IDLE); // R15 R12
  assign start_c    = spm_fire_c && (pgw_r || pge_r); // R8 R10
  assign fill_c     = spm_fire_c && !(pgw_r || pge_r || rre_r || blb_r || sig_r); // R12
  // a signature-armed store is a no-op and only disarms
  assign ctrl_clr_c = (spm_fire_c && !start_c) || (expire && (op_r == OP_IDLE)) || prog_done; // R5 R9 R13
  assign lpm_fire_c = lpm_exec && lpm_win && store_enable_r && (sig_r || blb_r); // R4 R7
  assign halt_sel_c = z_no_read_while_write_section_c || !RWW_SUPPORT; // R11 R18 R17

  // z[1:0]: 00 fuse low, 01 lock, 10 fuse ext, 11 fuse high; programmed reads 0
  assign fuse_sel_c = (z_ptr[1:0] == 2'h0) ? ~fuse_low_prog :
                      (z_ptr[1:0] == 2'h1) ? ~lock_prog :
                      (z_ptr[1:0] == 2'h2) ? ~fuse_ext_prog : ~fuse_high_prog; // R7 R23
  assign lpm_byte_c = sig_r ? SIG_ROW[{z_ptr[2:1], 3'h0} +: 8] : fuse_sel_c; // R4

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // arm bits load on accepted patterns, clear on a non-programming store, completion or timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ie_r, sig_r, rre_r, blb_r, pgw_r, pge_r, store_enable_r} <= 7'h00;
    end else begin
      if (wr_csr_c) begin
        ie_r <= pwdata[B_IE];
      end
      if (cmd_ok_c) begin
        sig_r   <= pwdata[B_SIG] && (pat_c == PAT_SPM); // R4
        {rre_r, blb_r, pgw_r, pge_r, store_enable_r} <= pat_c; // R14
      end else if (ctrl_clr_c) begin
        {sig_r, rre_r, blb_r, pgw_r, pge_r, store_enable_r} <= 6'h00; // R9 R10 R13
      end
    end
  end

  // section busy: set by a rww-page operation, cleared by re-enable store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sbusy_r <= 1'b0;
    end else if (start_c && !halt_sel_c) begin
      sbusy_r <= 1'b1; // R19
    end else if (spm_fire_c && rre_r) begin
      sbusy_r <= 1'b0; // R19
    end
  end

  // ----------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------
  // page and kind latched at start so the pointer may move on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r        <= OP_IDLE;
      op_no_read_while_write_section_r   <= 1'b0;
      flash_page  <= 9'h000;
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      cpu_halt    <= 1'b0;
    end else begin
      flash_erase <= start_c && pge_r; // R10
      flash_write <= start_c && pgw_r; // R8
      if (start_c) begin
        op_r       <= pge_r ? OP_ERASE : OP_WRITE;
        op_no_read_while_write_section_r  <= halt_sel_c;
        flash_page <= z_ptr[15:7]; // R22
        cpu_halt   <= halt_sel_c; // R25 R11 R18
      end else if (prog_done) begin
        op_r     <= OP_IDLE;
        cpu_halt <= 1'b0; // R25
      end
    end
  end

  // ----------------------------------------------------------------
  // temporary page buffer
  // ----------------------------------------------------------------
  // valid bits clear the whole buffer in one cycle; invalid reads erased
  always_comb begin
    buf_vld_nxt = buf_vld_r;
    if (fill_c) begin
      buf_vld_nxt[z_ptr[6:1]] = 1'b1; // R12
    end
    if ((cmd_ok_c && (pat_c == PAT_RRE)) || (prog_done && (op_r == OP_WRITE))) begin
      buf_vld_nxt = '0; // R6
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_vld_r <= '0;
    end else begin
      buf_vld_r <= buf_vld_nxt;
    end
  end

  // word write ignores pointer bit 0
  always_ff @(posedge pclk) begin
    if (fill_c) begin
      buf_mem[z_ptr[6:1]] <= data_pair; // R12
    end
  end

  // buffer read port for the page write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_rd_data <= 16'h0000;
    end else begin
      buf_rd_data <= buf_vld_r[buf_rd_idx] ? buf_mem[buf_rd_idx] : ERASED_WORD; // R8
    end
  end

  // ----------------------------------------------------------------
  // load answer and ready request
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpm_valid <= 1'b0;
      lpm_data  <= 8'h00;
      ready_irq <= 1'b0;
    end else begin
      lpm_valid <= lpm_fire_c;
      if (lpm_fire_c) begin
        lpm_data <= lpm_byte_c; // R4 R7
      end
      ready_irq <= ie_r && global_int_en && !store_enable_r && !ee_write_busy && (op_r == OP_IDLE); // R1 R2
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  irq_when_ready_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    ie_r && global_int_en && !store_enable_r && !ee_write_busy |=> ready_irq)
    else $error("ready request missing");

  irq_quiet_busy_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (ee_write_busy || (op_r != OP_IDLE)) |=> !ready_irq)
    else $error("ready request during store or eeprom write");

  sbusy_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (!RWW_SUPPORT && pready && psel && hit_c) |-> !prdata[B_SBSY])
    else $error("section busy read as one");

  sig_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
    spm_fire_c && sig_r |=> (op_r == OP_IDLE) && (buf_vld_r == $past(buf_vld_r)) && !store_enable_r)
    else $error("signature store had an effect");

  buf_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    cmd_ok_c && (pat_c == PAT_RRE) |=> (buf_vld_r == '0))
    else $error("page buffer not cleared");

  lock_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    lpm_fire_c && blb_r && (z_ptr[1:0] == 2'h1) |=> lpm_valid && (lpm_data == ~$past(lock_prog)))
    else $error("lock byte wrong");

  arm_timeout_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    $rose(store_enable_r) && (op_r == OP_IDLE) && !spm_exec && !cmd_ok_c ##1 (!spm_exec && !cmd_ok_c)[*3]
      |=> !store_enable_r && !pgw_r && !pge_r)
    else $error("arm bits outlived window");

  store_enable_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (op_r != OP_IDLE) |-> store_enable_r && (pgw_r || pge_r))
    else $error("store enable dropped during operation");

  pattern_filter_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
    wr_csr_c && !pat_ok_c && (op_r == OP_IDLE) && !spm_win |=> !store_enable_r)
    else $error("illegal pattern took effect");

  app_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
    (op_r == OP_IDLE) && spm_exec && !in_boot_c |=> (op_r == OP_IDLE) && !flash_erase && !flash_write)
    else $error("store from application section started programming");

  halt_no_read_while_write_section_a: assert property (@(posedge pclk) disable iff (!presetn) // R18
    start_c && halt_sel_c |=> cpu_halt throughout (op_r != OP_IDLE)[*3])
    else $error("cpu not halted for no_read_while_write_section page");

  page_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // R22
    (op_r != OP_IDLE) && !start_c |=> $stable(flash_page))
    else $error("page address moved during operation");

  halt_whole_op_a: assert property (@(posedge pclk) disable iff (!presetn) // R18 R11
    (op_r != OP_IDLE) && op_no_read_while_write_section_r |-> cpu_halt)
    else $error("cpu ran during no_read_while_write_section page operation");

  rww_runs_a: assert property (@(posedge pclk) disable iff (!presetn) // R17 R19
    start_c && !halt_sel_c |=> !cpu_halt && sbusy_r)
    else $error("rww page operation halted cpu or left section free");

  store_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    spm_fire_c && !start_c && !cmd_ok_c |=> !store_enable_r && !spm_win)
    else $error("store enable outlived its store");

  op_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // R8 R10
    start_c |=> (flash_erase != flash_write) && (op_r != OP_IDLE))
    else $error("operation start pulse wrong");

  write_done_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
    prog_done && (op_r == OP_WRITE) |=> (buf_vld_r == '0) && !pgw_r && !store_enable_r && (op_r == OP_IDLE))
    else $error("page write did not finish cleanly");

  sig_load_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
    lpm_fire_c && sig_r && (z_ptr[2:1] == 2'h0) |=> lpm_valid && (lpm_data == SIG_ROW[7:0]))
    else $error("signature byte wrong");

  load_window_a: assert property (@(posedge pclk) disable iff (!presetn) // R4 R7
    lpm_exec && !lpm_win |=> !lpm_valid)
    else $error("load answered outside its window");

  erase_cov: cover property (@(posedge pclk) disable iff (!presetn) start_c && pge_r);
  write_cov: cover property (@(posedge pclk) disable iff (!presetn) start_c && pgw_r ##[1:1000] prog_done);
  fill_cov:  cover property (@(posedge pclk) disable iff (!presetn) fill_c);
  sig_cov:   cover property (@(posedge pclk) disable iff (!presetn) lpm_fire_c && sig_r);
  rre_cov:   cover property (@(posedge pclk) disable iff (!presetn) spm_fire_c && rre_r);

endmodule // fspc_top

/* File: rtl/fspc_pkg.sv */
// constants and types for the flash self-program control block
// Contract
// R1: ready request while enabled, gie and store-enable low
// R2: no ready request during eeprom write or store
// R3: section-busy reads zero without read-while-write
// R4: signature byte returned by load within three cycles
// R5: store after signature arm changes nothing
// R6: section-read-enable write clears the page buffer
// R7: lock or fuse bits returned, pointer bit0 selects; the code selects one of four bytes with pointer bits 1:0
// R8: page write from buffer at latched page
// R9: page-write bit clears on completion or timeout
// R10: page erase at pointer page, self-clearing bit
// R11: no read-while-write variant halts every operation
// R12: store-enable alone loads pair into buffer word
// R13: store-enable clears after store, holds during operation
// R14: only five control patterns take effect
// R15: stores start programming only from boot section
// R16: boot stores may program any page
// R17: read-while-write page operation keeps cpu running
// R18: no-read-while-write page operation halts cpu
// R19: section-busy set while blocked, software clears it
// R20: software avoids blocked section during programming
// R21: boot size from fuses, always inside no_read_while_write_section
// R22: page address latched at operation start
// R23: programmed fuse bits read zero, unprogrammed one
// R24: arming window is a reloaded down-counter
// R25: halt output from busy flag until completion
package fspc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CSR_INDEX = 8'h37;                     // printed offset, word index
  localparam logic [11:0] CSR_ADDR  = {2'h0, CSR_INDEX, 2'h0};   // byte address, index times four
  localparam logic [7:0]  CSR_RESET = 8'h00;

  // bit positions
  localparam int B_IE   = 7;
  localparam int B_SBSY = 6;
  localparam int B_SIG  = 5;

  // accepted lower five bit patterns
  localparam logic [4:0] PAT_RRE  = 5'h11;
  localparam logic [4:0] PAT_BLB  = 5'h09;
  localparam logic [4:0] PAT_PGW  = 5'h05;
  localparam logic [4:0] PAT_PGE  = 5'h03;
  localparam logic [4:0] PAT_SPM  = 5'h01;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          PROG_TIME_NS  = 3_700_000;              // least programming time
  localparam int          PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  ARM_SPM_CYC   = 3'h4;                   // store window
  localparam logic [2:0]  ARM_LPM_CYC   = 3'h3;                   // load window
  localparam logic [2:0]  ARM_LPM_MIN   = ARM_SPM_CYC - ARM_LPM_CYC + 3'h1;

  // ----------------------------------------------------------------
  // flash geometry
  // ----------------------------------------------------------------
  localparam int          PAGE_WORDS  = 64;
  localparam logic [14:0] FLASH_WORDS_M1 = 15'h3FFF;
  localparam logic [14:0] NO_READ_WHILE_WRITE_SECTION_START  = 15'h3800;
  localparam logic [14:0] BOOT_W_00   = 15'h0800;
  localparam logic [14:0] BOOT_W_01   = 15'h0400;
  localparam logic [14:0] BOOT_W_10   = 15'h0200;
  localparam logic [14:0] BOOT_W_11   = 15'h0100;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE} fspc_op_type;

endpackage

/* File: rtl/fspc_arm_window.sv */
// arming window down-counter for store and load instructions
`timescale 1ns/1ps
module fspc_arm_window (
  input  wire logic pclk,      // cpu clock
  input  wire logic presetn,   // async reset, low
  input  wire logic load,      // valid control write
  input  wire logic stop,      // window consumed
  output logic      spm_win,   // store allowed
  output logic      lpm_win,   // load allowed
  output logic      expire     // last cycle of window
);
  import fspc_pkg::*;

  logic [2:0] cnt_r;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // reload on every accepted write, count down to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 3'h0;
    end else if (load) begin
      cnt_r <= ARM_SPM_CYC; // R24
    end else if (stop) begin
      cnt_r <= 3'h0;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end

  // window decode
  assign spm_win = (cnt_r != 3'h0);
  assign lpm_win = (cnt_r >= ARM_LPM_MIN);
  assign expire  = (cnt_r == 3'h1) && !load && !stop; // R24

endmodule // fspc_arm_window

/* File: rtl/fspc_prog_timer.sv */
// programming time sequencer for erase and write
`timescale 1ns/1ps
module fspc_prog_timer #(
  parameter int unsigned PROG_CYC = 185000      // cycles per operation
) (
  input  wire logic pclk,      // cpu clock
  input  wire logic presetn,   // async reset, low
  input  wire logic start,     // operation accepted
  output logic      done       // one-cycle completion pulse
);
  import fspc_pkg::*;

  logic [17:0] cnt_r;
  logic        run_r;
  logic [17:0] last_c;

  assign last_c = 18'(PROG_CYC - 1);

  // ----------------------------------------------------------------
  // timer
  // ----------------------------------------------------------------
  // runs from start until the full programming time has passed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 18'h0;
      run_r <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= run_r && (cnt_r == last_c);
      if (start && !run_r) begin
        run_r <= 1'b1;
        cnt_r <= 18'h0;
      end else if (run_r && (cnt_r == last_c)) begin
        run_r <= 1'b0;
      end else if (run_r) begin
        cnt_r <= cnt_r + 18'h1;
      end
    end
  end

endmodule // fspc_prog_timer

/* File: tb/fspc_core_model.sv */
// processor core model issuing store and load instruction pulses
`timescale 1ns/1ps
module fspc_core_model (
  input  wire logic pclk,     // cpu clock
  input  wire logic presetn,  // async reset, low
  input  wire logic halt,     // core halted by the block
  input  wire logic req_spm,  // bench asks for a store
  input  wire logic req_lpm,  // bench asks for a load
  output logic      spm_exec, // store pulse
  output logic      lpm_exec  // load pulse
);
  // a halted core fetches nothing, so it issues no instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spm_exec <= 1'b0;
      lpm_exec <= 1'b0;
    end else begin
      spm_exec <= req_spm & !halt;
      lpm_exec <= req_lpm & !halt;
    end
  end
endmodule // fspc_core_model

/* File: tb/test_flash_self_program_control.sv */
// self-checking testbench for the flash self-program control block
`timescale 1ns/1ps
module test_flash_self_program_control;
  import fspc_pkg::*;
  localparam logic [31:0] SIG = 32'hC3A5_1E78; // arbitrary signature bytes
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, perr;
  logic spm_exec, lpm_exec, req_spm = 0, req_lpm = 0, global_int_en = 0, ee_write_busy = 0;
  logic lpm_valid, ready_irq, cpu_halt, flash_erase, flash_write;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [15:0] z_ptr = '0, data_pair = '0, buf_rd_data, w;
  logic [14:0] cpu_pc = 15'h3F00;
  logic [1:0]  section_size_fuses = 2'h0;
  logic [7:0]  fl = 8'h00, fh = 8'h00, fe = 8'h00, lk = 8'h00, lpm_data;
  logic [5:0]  buf_rd_idx = '0;
  logic [8:0]  flash_page;
  logic [31:0] prdata_s, r_s;
  logic        halt_s;
  int fails = 0, n_checks = 0;
  always #10 pclk = ~pclk;
  fspc_top #(.PROG_CYC(20), .SIG_ROW(SIG)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .spm_exec, .lpm_exec, .z_ptr, .data_pair, .cpu_pc,
    .global_int_en, .ee_write_busy, .section_size_fuses, .fuse_low_prog(fl), .fuse_high_prog(fh),
    .fuse_ext_prog(fe), .lock_prog(lk), .buf_rd_idx, .buf_rd_data, .lpm_valid, .lpm_data,
    .ready_irq, .cpu_halt, .flash_erase, .flash_write, .flash_page);
  // small variant without read-while-write, fed the same stimulus
  fspc_top #(.RWW_SUPPORT(1'b0), .PROG_CYC(20), .SIG_ROW(SIG)) u_dut_small (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata(prdata_s), .pready(), .pslverr(), .spm_exec, .lpm_exec, .z_ptr, .data_pair,
    .cpu_pc, .global_int_en, .ee_write_busy, .section_size_fuses, .fuse_low_prog(fl), .fuse_high_prog(fh),
    .fuse_ext_prog(fe), .lock_prog(lk), .buf_rd_idx, .buf_rd_data(), .lpm_valid(), .lpm_data(), .ready_irq(),
    .cpu_halt(halt_s), .flash_erase(), .flash_write(), .flash_page());
  fspc_core_model u_core (.pclk, .presetn, .halt(cpu_halt), .req_spm, .req_lpm, .spm_exec, .lpm_exec);
  // ----------------------------------------------------------------
  // tasks and expectations
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    r = prdata; r_s = prdata_s; perr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // store (s=1) or load (s=0), result checked just after the sampling edge
  task automatic op(input logic s, input logic [15:0] z, input logic [14:0] pc);
    z_ptr <= z; cpu_pc <= pc; req_spm <= s; req_lpm <= !s;
    @(posedge pclk); req_spm <= 0; req_lpm <= 0;
    @(posedge pclk); #1;
  endtask
  function automatic logic [7:0] fuseb(input logic [1:0] k);
    case (k)
      2'd0: return ~fl;
      2'd1: return ~lk;
      2'd2: return ~fe;
      default: return ~fh;
    endcase
  endfunction
  initial begin #(20 * 5000); fails++; final_report(); end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    r = $urandom(80);
    {fl, fh, fe, lk} = $urandom;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, CSR_ADDR, 0); chk(r, 0);
    apb(0, 12'h0E0, 0); chk(perr, 1);
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      w = $urandom; buf_rd_idx <= $urandom; data_pair <= w;
      apb(1, CSR_ADDR, PAT_SPM); data_pair <= w;
      op(1, {9'h0, buf_rd_idx, 1'b1}, 15'h3F00);
      @(posedge pclk); #1 chk(buf_rd_data, w);
      apb(0, CSR_ADDR, 0); chk(r, 0);
    end
    apb(1, CSR_ADDR, PAT_RRE); repeat (2) @(posedge pclk); #1 chk(buf_rd_data, 16'hFFFF);
    apb(1, CSR_ADDR, PAT_SPM); apb(0, CSR_ADDR, 0); chk(r, 1);
    repeat (5) @(posedge pclk); apb(0, CSR_ADDR, 0); chk(r, 0);
    apb(1, CSR_ADDR, 8'h87); apb(0, CSR_ADDR, 0); chk(r, 8'h80);
    apb(1, CSR_ADDR, 8'h00);
    $display("arming test done");
    apb(1, CSR_ADDR, PAT_PGE); op(1, 16'h1080, 15'h3F00);
    chk(flash_erase, 1); chk(cpu_halt, 0); chk(halt_s, 1);
    @(posedge pclk); z_ptr <= '0;
    #1 chk(flash_page, 9'h021);
    apb(0, CSR_ADDR, 0); chk(r, 8'h43); chk(r_s, 8'h03);
    repeat (25) @(posedge pclk); apb(0, CSR_ADDR, 0); chk(r, 8'h40);
    apb(1, CSR_ADDR, PAT_RRE); op(1, 16'h1080, 15'h3F00);
    apb(0, CSR_ADDR, 0); chk(r, 0);
    apb(1, CSR_ADDR, PAT_PGW); op(1, 16'h7100, 15'h3F00);
    chk(flash_write, 1); chk(cpu_halt, 1); chk(flash_page, 9'h0E2);
    repeat (25) @(posedge pclk); #1 chk(cpu_halt, 0);
    apb(0, CSR_ADDR, 0); chk(r, 0);
    apb(1, CSR_ADDR, PAT_PGE); op(1, 16'h1080, 15'h0100); chk(flash_erase, 0);
    apb(1, CSR_ADDR, PAT_PGE); section_size_fuses <= 2'h3; op(1, 16'h1080, 15'h3EFF); chk(flash_erase, 0);
    $display("programming test done");
    for (int k = 0; k < 4; k++) begin
      apb(1, CSR_ADDR, 8'h21); op(0, {13'h0, k[1:0], 1'b0}, 15'h3F00);
      chk(lpm_valid, 1); chk(lpm_data, SIG[8*k +: 8]);
      apb(1, CSR_ADDR, PAT_BLB); op(0, {14'h0, k[1:0]}, 15'h3F00);
      chk(lpm_valid, 1); chk(lpm_data, fuseb(k[1:0]));
    end
    apb(1, CSR_ADDR, PAT_BLB); repeat (2) @(posedge pclk); op(0, 16'h0001, 15'h3F00); chk(lpm_valid, 0);
    @(posedge pclk); buf_rd_idx <= 0; data_pair <= 16'h1234;
    apb(1, CSR_ADDR, 8'h21); op(1, 16'h0000, 15'h3F00);
    @(posedge pclk); #1 chk(buf_rd_data, 16'hFFFF);
    $display("load test done");
    @(posedge pclk); global_int_en <= 1;
    apb(1, CSR_ADDR, 8'h80); repeat (3) @(posedge pclk); #1 chk(ready_irq, 1);
    @(posedge pclk); ee_write_busy <= 1;
    repeat (3) @(posedge pclk); #1 chk(ready_irq, 0);
    $display("ready request test done");
    final_report();
  end
endmodule // test_flash_self_program_control
